//--- cfe_flags_top.sv
// Flag generation, flag register and condition test for an 8-bit core.
// Assumes execution logic presents one operation per valid cycle with its
// operands, and software reaches the flag register over classic Wishbone.
`timescale 1ns/1ps
module cfe_flags_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Execution side
  input wire logic op_valid,
  input wire cfe_pkg::cfe_op_e op_code,
  input wire logic [15:0] op_dst,
  input wire logic [7:0] op_src,
  output logic [15:0] op_result,
  output logic op_done,
  output logic [7:0] flags,
  // Condition test
  input wire logic [3:0] condition_field,
  output logic condition_true
);
  import cfe_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] flags_q; // Flag register
  logic [7:0] flags_d; // Its next value
  logic [15:0] result_q; // Last operation result
  logic done_q; // Result valid pulse
  logic ack_q; // Bus acknowledge
  logic [31:0] rdata_q; // Bus read data

  // ----------------------------------------------------------------
  // Operand taps
  // ----------------------------------------------------------------
  wire logic [7:0] a_w = op_dst[7:0]; // Accumulator byte
  wire logic [7:0] b_w = op_src; // Second operand
  wire logic cin_w = flags_q[CFE_C_BIT]; // Carry in
  wire logic is_adc_w = (op_code == CFE_OP_ADD_CARRY);
  wire logic is_sbw_w = (op_code == CFE_OP_BORROW_DIFFERENCE);

  // ----------------------------------------------------------------
  // Adders
  // ----------------------------------------------------------------
  // Carry in only for the with-carry variants
  wire logic add_cin_w = is_adc_w & cin_w;
  wire logic sub_bin_w = is_sbw_w & cin_w;
  // Ninth bit is the carry out of bit 7
  wire logic [8:0] sum_w = {1'b0, a_w} + {1'b0, b_w} + {8'h00, add_cin_w}; // [RL3]
  // Fifth bit is the carry out of bit 3
  wire logic [4:0] sum_lo_w = {1'b0, a_w[3:0]} + {1'b0, b_w[3:0]} + {4'h0, add_cin_w}; // [RL10]
  // Ninth bit is the borrow out of bit 7
  wire logic [8:0] dif_w = {1'b0, a_w} - {1'b0, b_w} - {8'h00, sub_bin_w}; // [RL3]
  wire logic [4:0] dif_lo_w = {1'b0, a_w[3:0]} - {1'b0, b_w[3:0]} - {4'h0, sub_bin_w}; // [RL10]
  // Signed overflow terms
  wire logic add_ovf_w = (a_w[7] == b_w[7]) & (sum_w[7] != a_w[7]); // [RL7]
  wire logic sub_ovf_w = (a_w[7] != b_w[7]) & (dif_w[7] != a_w[7]); // [RL7]

  // ----------------------------------------------------------------
  // Packed BCD correction
  // ----------------------------------------------------------------
  // Decimal flag says whether the last arithmetic was add or subtract
  wire logic bcd_sub_w = flags_q[CFE_D_BIT]; // [RL9]
  wire logic bcd_hi_w = bcd_sub_w ? cin_w : (cin_w | (a_w > CFE_BCD_MAX)); // [RL9]
  wire logic bcd_lo_w = flags_q[CFE_H_BIT] | (~bcd_sub_w & (a_w[3:0] > CFE_NIBBLE_MAX)); // [RL9]
  wire logic [7:0] bcd_corr_w = (bcd_hi_w ? CFE_BCD_HI_ADJ : 8'h00) | (bcd_lo_w ? CFE_BCD_LO_ADJ : 8'h00);
  wire logic [7:0] bcd_res_w = bcd_sub_w ? (a_w - bcd_corr_w) : (a_w + bcd_corr_w); // [RL9]

  // ----------------------------------------------------------------
  // Word and single-step arithmetic
  // ----------------------------------------------------------------
  wire logic [15:0] wrd_up_w = op_dst + 16'h0001;
  wire logic [15:0] wrd_dn_w = op_dst - 16'h0001;
  wire logic [7:0] byt_up_w = a_w + 8'h01;
  wire logic [7:0] byt_dn_w = a_w - 8'h01;

  // ----------------------------------------------------------------
  // Result and flag calculation
  // ----------------------------------------------------------------
  logic [15:0] res_c; // Result of the operation
  logic [7:0] calc_c; // Candidate flags
  logic [7:0] upd_c; // Which flags this class touches
  logic word_c; // Result is 16 bits wide
  logic zs_c; // Zero and sign come from the result

  // Per-class result, carry, overflow and update mask
  always_comb begin
    res_c = op_dst;
    calc_c = flags_q;
    upd_c = 8'h00;
    word_c = 1'b0;
    zs_c = 1'b1;
    case (op_code)
      CFE_OP_ADD, CFE_OP_ADD_CARRY: begin
        res_c = {8'h00, sum_w[7:0]};
        calc_c[CFE_C_BIT] = sum_w[8]; // [RL3]
        calc_c[CFE_V_BIT] = add_ovf_w; // [RL7]
        calc_c[CFE_D_BIT] = 1'b0; // [RL8]
        calc_c[CFE_H_BIT] = sum_lo_w[4]; // [RL10]
        upd_c = CFE_UPD_ARITH; // [RL2] [RL11]
      end
      CFE_OP_SUBTRACT, CFE_OP_BORROW_DIFFERENCE: begin
        res_c = {8'h00, dif_w[7:0]};
        calc_c[CFE_C_BIT] = dif_w[8]; // [RL3]
        calc_c[CFE_V_BIT] = sub_ovf_w; // [RL7]
        calc_c[CFE_D_BIT] = 1'b1; // [RL8]
        calc_c[CFE_H_BIT] = dif_lo_w[4]; // [RL10]
        upd_c = CFE_UPD_ARITH; // [RL2] [RL11]
      end
      CFE_OP_COMPARE: begin
        // Result only feeds the flags; destination is not written back
        res_c = {8'h00, dif_w[7:0]};
        calc_c[CFE_C_BIT] = dif_w[8];
        calc_c[CFE_V_BIT] = sub_ovf_w;
        upd_c = CFE_UPD_CZSV; // [RL2]
      end
      CFE_OP_DECIMAL_ADJUST: begin
        // Overflow is left alone: its value is meaningless here
        res_c = {8'h00, bcd_res_w};
        calc_c[CFE_C_BIT] = bcd_hi_w; // [RL9]
        upd_c = CFE_UPD_CZS; // [RL2]
      end
      CFE_OP_ROTATE_LEFT: begin
        res_c = {8'h00, a_w[6:0], a_w[7]};
        calc_c[CFE_C_BIT] = a_w[7];
        calc_c[CFE_V_BIT] = a_w[7] ^ a_w[6];
        upd_c = CFE_UPD_CZSV; // [RL2]
      end
      CFE_OP_ROTATE_LEFT_VIA_CARRY: begin
        res_c = {8'h00, a_w[6:0], cin_w};
        calc_c[CFE_C_BIT] = a_w[7];
        calc_c[CFE_V_BIT] = a_w[7] ^ a_w[6];
        upd_c = CFE_UPD_CZSV; // [RL2]
      end
      CFE_OP_ROTATE_RIGHT: begin
        res_c = {8'h00, a_w[0], a_w[7:1]};
        calc_c[CFE_C_BIT] = a_w[0];
        calc_c[CFE_V_BIT] = a_w[7] ^ a_w[0];
        upd_c = CFE_UPD_CZSV; // [RL2]
      end
      CFE_OP_ROTATE_RIGHT_VIA_CARRY: begin
        res_c = {8'h00, cin_w, a_w[7:1]};
        calc_c[CFE_C_BIT] = a_w[0];
        calc_c[CFE_V_BIT] = a_w[7] ^ cin_w;
        upd_c = CFE_UPD_CZSV; // [RL2]
      end
      CFE_OP_SWAP_NIBBLES: begin
        // Carry and overflow carry no meaning; cleared for determinism
        res_c = {8'h00, a_w[3:0], a_w[7:4]};
        calc_c[CFE_C_BIT] = 1'b0;
        calc_c[CFE_V_BIT] = 1'b0;
        upd_c = CFE_UPD_CZSV; // [RL2]
      end
      CFE_OP_INTERRUPT_RETURN: begin
        // All six implemented flags restored from the stacked copy
        calc_c = b_w & CFE_FLAGS_USED;
        upd_c = CFE_FLAGS_USED; // [RL2]
        zs_c = 1'b0;
      end
      CFE_OP_AND, CFE_OP_OR, CFE_OP_XOR, CFE_OP_INVERT_BITS: begin
        if (op_code == CFE_OP_AND) begin
          res_c = {8'h00, a_w & b_w};
        end else if (op_code == CFE_OP_OR) begin
          res_c = {8'h00, a_w | b_w};
        end else if (op_code == CFE_OP_XOR) begin
          res_c = {8'h00, a_w ^ b_w};
        end else begin
          res_c = {8'h00, ~a_w};
        end
        calc_c[CFE_V_BIT] = 1'b0;
        upd_c = CFE_UPD_ZSV; // [RL4]
      end
      CFE_OP_TEST_UNDER_MASK, CFE_OP_TEST_INVERTED_MASK: begin
        // Result only feeds the flags
        res_c = {8'h00, (op_code == CFE_OP_TEST_UNDER_MASK ? a_w : ~a_w) & b_w};
        calc_c[CFE_V_BIT] = 1'b0;
        upd_c = CFE_UPD_ZSV; // [RL4]
      end
      CFE_OP_ADD_ONE_BYTE: begin
        res_c = {8'h00, byt_up_w};
        calc_c[CFE_V_BIT] = ~a_w[7] & byt_up_w[7]; // [RL7]
        upd_c = CFE_UPD_ZSV; // [RL4]
      end
      CFE_OP_SUBTRACT_ONE_BYTE: begin
        res_c = {8'h00, byt_dn_w};
        calc_c[CFE_V_BIT] = a_w[7] & ~byt_dn_w[7]; // [RL7]
        upd_c = CFE_UPD_ZSV; // [RL4]
      end
      CFE_OP_ADD_ONE_WORD: begin
        res_c = wrd_up_w;
        word_c = 1'b1;
        calc_c[CFE_V_BIT] = ~op_dst[15] & wrd_up_w[15];
        upd_c = CFE_UPD_ZSV; // [RL4]
      end
      CFE_OP_SUBTRACT_ONE_WORD: begin
        res_c = wrd_dn_w;
        word_c = 1'b1;
        calc_c[CFE_V_BIT] = op_dst[15] & ~wrd_dn_w[15];
        upd_c = CFE_UPD_ZSV; // [RL4]
      end
      CFE_OP_FLIP_CARRY: begin
        calc_c[CFE_C_BIT] = ~cin_w;
        upd_c = CFE_UPD_C;
      end
      CFE_OP_CLEAR_CARRY: begin
        calc_c[CFE_C_BIT] = 1'b0;
        upd_c = CFE_UPD_C;
      end
      CFE_OP_SET_CARRY: begin
        calc_c[CFE_C_BIT] = 1'b1;
        upd_c = CFE_UPD_C;
      end
      default: begin
        upd_c = 8'h00; // No flag touched
      end
    endcase
    // Zero and sign follow the width of the result
    if (zs_c) begin
      calc_c[CFE_Z_BIT] = word_c ? (res_c == 16'h0000) : (res_c[7:0] == 8'h00); // [RL5]
      calc_c[CFE_S_BIT] = word_c ? res_c[15] : res_c[7]; // [RL6]
    end
  end

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  wire logic req_w = cyc_i & stb_i; // Live request
  wire logic hit_w = (adr_i == CFE_FLAGS_OFS); // Flag register selected
  // Write lands at the acknowledge edge; an operation in the same cycle wins
  wire logic bus_wr_w = req_w & we_i & ack_q & hit_w & sel_i[0] & ~op_valid;

  // ----------------------------------------------------------------
  // Per-bit flag next value
  // ----------------------------------------------------------------
  // Untouched flags hold so older results stay testable
  for (genvar i = 0; i < 8; i++) begin : g_flag
    assign flags_d[i] = op_valid ? (upd_c[i] ? calc_c[i] : flags_q[i]) // [RL15]
                      : (bus_wr_w ? (dat_i[i] & CFE_FLAGS_USED[i]) : flags_q[i]);
  end

  // Flag register [RL1]
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flags_q <= CFE_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Result register and completion pulse
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      result_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      result_q <= op_valid ? res_c : result_q;
      done_q <= op_valid;
    end
  end

  // Bus answer: one wait state, read data captured at request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req_w & ~ack_q;
      if (req_w & ~ack_q) begin
        rdata_q <= hit_w ? {24'h00_0000, flags_q} : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Condition evaluation
  // ----------------------------------------------------------------
  cfe_cond_if cond_bus ();
  assign cond_bus.flags = flags_q;
  assign cond_bus.field = condition_field;
  cfe_cond_eval u_cond (
    .cif(cond_bus)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dat_o = rdata_q;
  assign ack_o = ack_q;
  assign op_result = result_q;
  assign op_done = done_q;
  assign flags = flags_q;
  assign condition_true = cond_bus.taken;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ack_single: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ack_o |=> !ack_o) else $error("ack held longer than one cycle");

  a_subtract_sets_d: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL8]
    op_valid && (op_code == CFE_OP_SUBTRACT || op_code == CFE_OP_BORROW_DIFFERENCE)
    |=> flags_q[CFE_D_BIT]) else $error("decimal flag not set by subtract");

  a_add_clears_d: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL8]
    op_valid && (op_code == CFE_OP_ADD || op_code == CFE_OP_ADD_CARRY)
    |=> !flags_q[CFE_D_BIT]) else $error("decimal flag not cleared by add");

  a_add_carry_out: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL3]
    op_valid && op_code == CFE_OP_ADD
    |=> flags_q[CFE_C_BIT] == (({1'b0, $past(op_dst[7:0])} + {1'b0, $past(op_src)}) > 9'h0ff))
    else $error("carry does not match bit 7 carry out");

  a_half_carry_only: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL11]
    op_valid && !(op_code inside {CFE_OP_ADD, CFE_OP_ADD_CARRY, CFE_OP_SUBTRACT,
    CFE_OP_BORROW_DIFFERENCE, CFE_OP_INTERRUPT_RETURN})
    |=> $stable(flags_q[CFE_H_BIT])) else $error("half carry changed by wrong class");

  a_logic_keeps_c: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL15]
    op_valid && op_code inside {CFE_OP_AND, CFE_OP_OR, CFE_OP_XOR, CFE_OP_INVERT_BITS}
    |=> $stable(flags_q[CFE_C_BIT])) else $error("logic operation changed carry");

  a_zero_matches: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL5]
    op_valid && op_code inside {CFE_OP_AND, CFE_OP_SUBTRACT, CFE_OP_ADD_ONE_BYTE}
    |=> flags_q[CFE_Z_BIT] == (op_result[7:0] == 8'h00) && op_done)
    else $error("zero flag disagrees with result");

  a_sign_matches: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL6]
    op_valid && op_code inside {CFE_OP_OR, CFE_OP_ADD, CFE_OP_SUBTRACT_ONE_BYTE}
    |=> flags_q[CFE_S_BIT] == op_result[7]) else $error("sign flag disagrees with result");

  a_cond_fixed: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL12]
    (condition_field == CFE_CND_ALWAYS |-> condition_true)
    and (condition_field == CFE_CND_NEVER |-> !condition_true))
    else $error("fixed condition evaluated wrongly");

  a_cond_signed: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL14]
    condition_field == CFE_CND_SIGNED_ABOVE
    |-> condition_true == !(flags_q[CFE_Z_BIT] | (flags_q[CFE_S_BIT] ^ flags_q[CFE_V_BIT])))
    else $error("signed-above condition wrong");

endmodule : cfe_flags_top

//--- cfe_pkg.sv
// Constants, field layout and operation classes for the flag and condition unit.
// Assumes one synchronous clock domain and a classic Wishbone register path.
//
// Function
// RL1: Six flags held in flag register 252.
// RL2: Carry updated by add, subtract, rotate, swap, return.
// RL3: Arithmetic carry is carry out of bit 7.
// RL4: Zero updated by carry set plus logic, tests.
// RL5: Zero set when result equals zero.
// RL6: Sign updated like zero, equals result bit 7.
// RL7: Overflow set when signed result leaves byte range.
// RL8: Decimal flag set by subtract, cleared by add.
// RL9: Decimal adjust picks correction from decimal flag.
// RL10: Half carry is carry out of bit 3.
// RL11: Only add and subtract update half carry; here interrupt return also loads it from the stacked copy.
// RL12: Four-bit field; 1000 always, 0000 never.
// RL13: Single-flag condition codes test one flag.
// RL14: Compare codes combine sign, overflow, zero, carry.
// RL15: Unlisted flags keep their previous value.
package cfe_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CFE_FLAGS_OFS = 8'hfc; // Flag register byte address
  localparam logic [7:0] CFE_FLAGS_RST = 8'h00; // Flags after reset
  localparam logic [7:0] CFE_FLAGS_USED = 8'hfc; // Implemented bits, rest read zero

  // ----------------------------------------------------------------
  // Flag bit positions
  // ----------------------------------------------------------------
  localparam int CFE_C_BIT = 7; // Carry
  localparam int CFE_Z_BIT = 6; // Zero
  localparam int CFE_S_BIT = 5; // Sign
  localparam int CFE_V_BIT = 4; // Overflow
  localparam int CFE_D_BIT = 3; // Decimal adjust
  localparam int CFE_H_BIT = 2; // Half carry

  // ----------------------------------------------------------------
  // Update masks per instruction class
  // ----------------------------------------------------------------
  localparam logic [7:0] CFE_UPD_ARITH = 8'hfc; // C Z S V D H
  localparam logic [7:0] CFE_UPD_CZSV = 8'hf0; // C Z S V
  localparam logic [7:0] CFE_UPD_CZS = 8'he0; // C Z S
  localparam logic [7:0] CFE_UPD_ZSV = 8'h70; // Z S V
  localparam logic [7:0] CFE_UPD_C = 8'h80; // Carry only

  // ----------------------------------------------------------------
  // Packed BCD correction
  // ----------------------------------------------------------------
  localparam logic [7:0] CFE_BCD_HI_ADJ = 8'h60;
  localparam logic [7:0] CFE_BCD_LO_ADJ = 8'h06;
  localparam logic [7:0] CFE_BCD_MAX = 8'h99;
  localparam logic [3:0] CFE_NIBBLE_MAX = 4'h9;

  // ----------------------------------------------------------------
  // Condition field codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CFE_CND_NEVER = 4'h0;
  localparam logic [3:0] CFE_CND_SIGNED_BELOW = 4'h1;
  localparam logic [3:0] CFE_CND_SIGNED_AT_MOST = 4'h2;
  localparam logic [3:0] CFE_CND_UNSIGNED_AT_MOST = 4'h3;
  localparam logic [3:0] CFE_CND_RANGE_ERROR = 4'h4;
  localparam logic [3:0] CFE_CND_NEGATIVE = 4'h5;
  localparam logic [3:0] CFE_CND_ZERO = 4'h6;
  localparam logic [3:0] CFE_CND_CARRY = 4'h7;
  localparam logic [3:0] CFE_CND_ALWAYS = 4'h8;
  localparam logic [3:0] CFE_CND_SIGNED_AT_LEAST = 4'h9;
  localparam logic [3:0] CFE_CND_SIGNED_ABOVE = 4'ha;
  localparam logic [3:0] CFE_CND_UNSIGNED_ABOVE = 4'hb;
  localparam logic [3:0] CFE_CND_NO_RANGE_ERROR = 4'hc;
  localparam logic [3:0] CFE_CND_NONNEGATIVE = 4'hd;
  localparam logic [3:0] CFE_CND_NOT_NULL = 4'he;
  localparam logic [3:0] CFE_CND_NO_CARRY = 4'hf;

  // ----------------------------------------------------------------
  // Operation classes presented by the execution logic
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CFE_OP_NONE,
    CFE_OP_ADD,
    CFE_OP_ADD_CARRY,
    CFE_OP_SUBTRACT,
    CFE_OP_BORROW_DIFFERENCE,
    CFE_OP_COMPARE,
    CFE_OP_DECIMAL_ADJUST,
    CFE_OP_ROTATE_LEFT,
    CFE_OP_ROTATE_LEFT_VIA_CARRY,
    CFE_OP_ROTATE_RIGHT,
    CFE_OP_ROTATE_RIGHT_VIA_CARRY,
    CFE_OP_SWAP_NIBBLES,
    CFE_OP_INTERRUPT_RETURN,
    CFE_OP_AND,
    CFE_OP_OR,
    CFE_OP_XOR,
    CFE_OP_INVERT_BITS,
    CFE_OP_ADD_ONE_BYTE,
    CFE_OP_SUBTRACT_ONE_BYTE,
    CFE_OP_ADD_ONE_WORD,
    CFE_OP_SUBTRACT_ONE_WORD,
    CFE_OP_TEST_UNDER_MASK,
    CFE_OP_TEST_INVERTED_MASK,
    CFE_OP_FLIP_CARRY,
    CFE_OP_CLEAR_CARRY,
    CFE_OP_SET_CARRY
  } cfe_op_e;

endpackage : cfe_pkg

//--- cfe_cond_if.sv
// Carrier between the flag unit and its condition evaluator.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/1ps
interface cfe_cond_if;
  logic [7:0] flags; // Current flag register
  logic [3:0] field; // Condition field of the jump
  logic taken; // Condition holds

  modport eval (input flags, input field, output taken);
  modport core (output flags, output field, input taken);
endinterface : cfe_cond_if

//--- cfe_cond_eval.sv
// Condition field evaluator for jump and relative jump.
// Assumes flags arrive straight from the flag register; output is combinational.
`timescale 1ns/1ps
module cfe_cond_eval (
  cfe_cond_if.eval cif
);
  import cfe_pkg::*;

  // ----------------------------------------------------------------
  // Flag taps
  // ----------------------------------------------------------------
  wire logic c_w = cif.flags[CFE_C_BIT]; // Carry
  wire logic z_w = cif.flags[CFE_Z_BIT]; // Zero
  wire logic s_w = cif.flags[CFE_S_BIT]; // Sign
  wire logic v_w = cif.flags[CFE_V_BIT]; // Overflow
  wire logic sv_w = s_w ^ v_w; // Signed less-than term
  logic [15:0] truth_w; // One truth bit per code

  // ----------------------------------------------------------------
  // Truth table, indexed by code
  // ----------------------------------------------------------------
  assign truth_w[CFE_CND_NEVER] = 1'b0; // [RL12]
  assign truth_w[CFE_CND_ALWAYS] = 1'b1; // [RL12]
  assign truth_w[CFE_CND_CARRY] = c_w; // [RL13]
  assign truth_w[CFE_CND_NO_CARRY] = ~c_w; // [RL13]
  assign truth_w[CFE_CND_ZERO] = z_w; // [RL13]
  assign truth_w[CFE_CND_NOT_NULL] = ~z_w; // [RL13]
  assign truth_w[CFE_CND_NEGATIVE] = s_w; // [RL13]
  assign truth_w[CFE_CND_NONNEGATIVE] = ~s_w; // [RL13]
  assign truth_w[CFE_CND_RANGE_ERROR] = v_w; // [RL13]
  assign truth_w[CFE_CND_NO_RANGE_ERROR] = ~v_w; // [RL13]
  assign truth_w[CFE_CND_SIGNED_AT_LEAST] = ~sv_w; // [RL14]
  assign truth_w[CFE_CND_SIGNED_BELOW] = sv_w; // [RL14]
  assign truth_w[CFE_CND_SIGNED_ABOVE] = ~(z_w | sv_w); // [RL14]
  assign truth_w[CFE_CND_SIGNED_AT_MOST] = z_w | sv_w; // [RL14]
  assign truth_w[CFE_CND_UNSIGNED_ABOVE] = ~c_w & ~z_w; // [RL14]
  assign truth_w[CFE_CND_UNSIGNED_AT_MOST] = c_w | z_w; // [RL14]

  // Pick the selected condition
  assign cif.taken = truth_w[cif.field];

endmodule : cfe_cond_eval

//--- tb_cfe_flags_top.sv
// Self-checking bench for the flag unit: register bus, operations, condition test.
// Assumes one 20 MHz clock, synchronous reset and a one-wait-state Wishbone slave.
`timescale 1ns/1ps
module tb_cfe_flags_top;
  import cfe_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic ref_clk = 1'b0, sys_rst = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0; // Bus controls idle
  logic [7:0] adr_i = 8'h00; // Bus address
  logic [3:0] sel_i = 4'hf; // Byte selects
  logic [31:0] dat_i = 32'h0; // Write data
  logic op_valid = 1'b0; // Operation strobe
  cfe_op_e op_code = CFE_OP_NONE; // Operation class
  logic [15:0] op_dst = 16'h0; // Destination operand
  logic [7:0] op_src = 8'h0; // Source operand
  logic [3:0] condition_field = 4'h0; // Code under test
  logic [31:0] dat_o; // Read data
  logic ack_o, op_done, condition_true; // Answers
  logic [15:0] op_result; // Operation result
  logic [7:0] flags; // Flag register
  int errors = 0, samples_checked = 0; // Verdict counters
  logic [31:0] seed = 32'h10614910; // Random source state
  logic [7:0] m = 8'h00; // Expected flag register
  logic [23:0] oq[$]; // Notes: result byte, mask and expected flags
  logic [31:0] rq[$]; // Notes: expected read data
  logic cq[$]; // Notes: expected condition outcome
  logic cv = 1'b0; // A condition code is under test this cycle
  logic [23:0] e; // Note under comparison
  always #25 ref_clk = ~ref_clk; // 50 ns period
  cfe_flags_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .op_valid(op_valid),
    .op_code(op_code), .op_dst(op_dst), .op_src(op_src), .op_result(op_result), .op_done(op_done),
    .flags(flags), .condition_field(condition_field), .condition_true(condition_true));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task end_of_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr
  // Low three bits pick the test, the top bit inverts it
  function automatic logic cnd(logic [7:0] f, logic [3:0] c);
    logic b;
    case (c[2:0])
      3'h0: b = 1'b0;
      3'h1: b = f[5] ^ f[4];
      3'h2: b = f[6] | (f[5] ^ f[4]);
      3'h3: b = f[7] | f[6];
      3'h4: b = f[4];
      3'h5: b = f[5];
      3'h6: b = f[6];
      default: b = f[7];
    endcase
    return c[3] ? ~b : b;
  endfunction : cnd
  // Classic cycle; request held until ack is sampled, then one idle cycle
  task bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    int i;
    @(posedge ref_clk);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
    for (i = 0; i < 20 && ack_o !== 1'b1; i++) @(posedge ref_clk);
    if (ack_o !== 1'b1) begin
      errors++;
      end_of_test;
    end
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task rd(logic [7:0] a, logic [31:0] x);
    rq.push_back(x);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rd
  // Walk all sixteen codes; the monitor compares one note per cycle
  task codes;
    for (int j = 0; j < 16; j++) begin
      @(posedge ref_clk);
      condition_field <= j[3:0];
      cv <= 1'b1;
      cq.push_back(cnd(m, j[3:0]));
    end
    @(posedge ref_clk);
    cv <= 1'b0;
  endtask : codes
  // Reference flag model; mask hides bits whose convention is left open
  task op(cfe_op_e c, logic [7:0] d, logic [7:0] s);
    logic [7:0] n, k, r;
    logic [8:0] sum;
    logic [4:0] h;
    logic ci;
    k = 8'hff; n = m; ci = (c == CFE_OP_ADD_CARRY) ? m[7] : 1'b0;
    r = d; // Result passes the destination through by default
    sum = {1'b0, d} + {1'b0, s} + {8'h0, ci};
    h = {1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, ci};
    case (c)
      CFE_OP_ADD, CFE_OP_ADD_CARRY: begin
        r = sum[7:0];
        n = {sum[8], sum[7:0] == 8'h0, sum[7], d[7] == s[7] && sum[7] != d[7], 1'b0, h[4], 2'b00};
      end
      // Addition-side correction only: call right after an add
      CFE_OP_DECIMAL_ADJUST: begin
        ci = m[7] || d > CFE_BCD_MAX;
        r = d + (ci ? CFE_BCD_HI_ADJ : 8'h00) + ((m[2] || d[3:0] > CFE_NIBBLE_MAX) ? CFE_BCD_LO_ADJ : 8'h00);
        n = {ci, r == 8'h0, r[7], m[4:2], 2'b00};
      end
      CFE_OP_SUBTRACT: begin
        r = d - s;
        n = {m[7], r == 8'h0, r[7], d[7] != s[7] && r[7] != d[7], 1'b1, m[2], 2'b00};
        k = 8'h7b; // Borrow sense of carry and half carry not checked
      end
      CFE_OP_AND: begin
        r = d & s;
        n = {m[7], r == 8'h0, r[7], 1'b0, m[3:2], 2'b00}; // Carry, decimal, half carry kept
      end
      CFE_OP_ROTATE_LEFT: begin
        r = {d[6:0], d[7]};
        n = {d[7], r == 8'h0, r[7], r[7] ^ d[7], m[3:2], 2'b00}; // Half carry kept
      end
      default: ;
    endcase
    @(posedge ref_clk);
    op_valid <= 1'b1; op_code <= c; op_dst <= {8'h00, d}; op_src <= s;
    oq.push_back({r, k, n});
    m = n;
  endtask : op
  // ------------------------------------------------------------
  // Monitor: oldest note against each result as it appears
  // ------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (op_done === 1'b1) begin
      e = (oq.size() > 0) ? oq.pop_front() : 24'hffffff;
      check("flags", {24'h0, e[7:0] & e[15:8]}, {24'h0, flags & e[15:8]});
      check("op_result", {24'h0, e[23:16]}, {16'h0, op_result});
    end
    if (ack_o === 1'b1 && we_i === 1'b0) check("dat_o", (rq.size() > 0) ? rq.pop_front() : 32'hdead, dat_o);
    if (cv === 1'b1) check("condition_true", {31'h0, cq.pop_front()}, {31'h0, condition_true});
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(CFE_FLAGS_OFS, {24'h0, CFE_FLAGS_RST});
    bus(1'b1, 8'h10, 32'hff, 4'hf); // Unmapped write must not land
    rd(8'h10, 32'h0);
    rd(CFE_FLAGS_OFS, 32'h0);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      m = seed[7:0] & CFE_FLAGS_USED;
      bus(1'b1, CFE_FLAGS_OFS, seed, 4'hf);
      rd(CFE_FLAGS_OFS, {24'h0, m});
      codes;
    end
    bus(1'b1, CFE_FLAGS_OFS, 32'h0, 4'he); // Byte 0 not selected, ignored
    rd(CFE_FLAGS_OFS, {24'h0, m});
    op(CFE_OP_ADD, 8'h80, 8'h80);
    op(CFE_OP_ADD, 8'h0f, 8'h01);
    op(CFE_OP_ADD, 8'hff, 8'h01);
    op(CFE_OP_ADD_CARRY, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      op(CFE_OP_AND, seed[7:0], seed[15:8]);
      op(CFE_OP_ROTATE_LEFT, seed[23:16], 8'h00);
    end
    op(CFE_OP_NONE, 8'h00, 8'h00);
    @(posedge ref_clk);
    op_valid <= 1'b0;
    codes;
    op(CFE_OP_SUBTRACT, 8'h01, 8'h02);
    op(CFE_OP_SUBTRACT, 8'h80, 8'h01);
    op(CFE_OP_ADD, 8'h05, 8'h03);
    op(CFE_OP_ADD, 8'h15, 8'h27);
    op(CFE_OP_DECIMAL_ADJUST, 8'h3c, 8'h00);
    @(posedge ref_clk);
    op_valid <= 1'b0;
    rd(CFE_FLAGS_OFS, {24'h0, m});
    repeat (2) @(posedge ref_clk);
    end_of_test;
  end
endmodule : tb_cfe_flags_top
